// [core/mrc_defines.svh]
`ifndef MRC_DEFINES_SVH
`define MRC_DEFINES_SVH

// register offsets
`define MRC_ADDR_RESET 8'h03
`define MRC_ADDR_DEVICE_CONFIG_PRIMARY 8'h04

// soft reset register fields
`define MRC_RST_TRIGGER_BIT 0

// configuration register fields
`define MRC_CFG_SYNC_BIT 15
`define MRC_CFG_TXFCS_BIT 14
`define MRC_CFG_CSALIGN_BIT 13
`define MRC_CFG_ZALIGN_BIT 12
`define MRC_CFG_THR_MSB 11
`define MRC_CFG_THR_LSB 10
`define MRC_CFG_LOW_MSB 9
`define MRC_CFG_LOW_LSB 0
`define MRC_CFG_LOW_VALUE 10'h006
`define MRC_CFG_THR_RESET 2'h0

// credit threshold encodings
`define MRC_THR_ENC_1 2'h0
`define MRC_THR_ENC_4 2'h1
`define MRC_THR_ENC_8 2'h2
`define MRC_THR_VAL_1 5'h01
`define MRC_THR_VAL_4 5'h04
`define MRC_THR_VAL_8 5'h08
`define MRC_THR_VAL_16 5'h10

// chip select hold time
`define MRC_CLK_PERIOD_NS 10
`define MRC_CS_MIN_NS 100
`define MRC_CS_MIN_CYC ((`MRC_CS_MIN_NS + `MRC_CLK_PERIOD_NS - 1) / `MRC_CLK_PERIOD_NS)
`define MRC_CS_CNT_W 4

`endif

// [core/mrc_pkg.sv]
package mrc_pkg;

  typedef enum logic [1:0] {
    MRC_RST_IDLE,
    MRC_RST_ARMED,
    MRC_RST_FIRE
  } mrc_rst_state_type;

  typedef logic [31:0] mrc_word_type;
  typedef logic [7:0] mrc_addr_type;

endpackage

// [core/mrc_sync.sv]
`timescale 1ns/100ps
`default_nettype none

module mrc_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_q;
  logic sync_q;

  // two flops, nothing reads the first but the second
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // mrc_sync

`default_nettype wire

// [core/mrc_regs.sv]
`timescale 1ns/100ps
`default_nettype none
`include "mrc_defines.svh"

// What this block does
// - Writing one to the soft reset bit returns the whole device and all its registers to defaults.
// - The soft reset is held back until chip select is released after the write, and is dropped if chip select was low for fewer than 10 cycles.
// - The soft reset bit clears itself and never reads back as set.
// - The configured flag is copied into the flag bit of every receive chunk footer.
// - The configured flag is write-one-to-set and only a reset clears it.
// - After any reset the configured flag clears, reset-complete sets and the interrupt asserts.
// - With check sequence validation on, the last four octets of each frame are checked.
// - With select alignment on, frames start only in the first chunk after chip select asserts.
// - With select alignment off, a frame may start in any chunk of a transfer.
// - With zero alignment on, frames start at the payload start with a start word offset of zero.
// - With zero and select alignment both off, a frame may start at any word of a chunk payload.
// - The free-credit interrupt asserts only once credits reach the threshold of 1, 4, 8 or 16.
// - Alignment and credit threshold settings act only under the chunked protocol.
module mrc_regs #(
  parameter int CREDIT_W = 6
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic spi_cs_n,
  input wire logic oa_protocol_sel,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire mrc_pkg::mrc_addr_type reg_addr,
  input wire mrc_pkg::mrc_word_type reg_wr_data,
  input wire logic reset_complete_clear,
  input wire logic [CREDIT_W-1:0] free_tx_credits,
  input wire logic rx_chunk_first,
  input wire logic rx_word_at_chunk_start,
  output mrc_pkg::mrc_word_type reg_rd_data_q,
  output logic reg_rd_valid_q,
  output logic device_soft_reset_q,
  output logic footer_sync_q,
  output logic tx_check_seq_validate_en_q,
  output logic select_aligned_rx_frame_en_q,
  output logic zero_aligned_rx_frame_en_q,
  output logic rx_frame_start_ok_q,
  output logic reset_complete_flag_q,
  output logic tx_credit_irq_q,
  output logic host_interrupt_n_q
);
  import mrc_pkg::*;

  function automatic logic addr_is(input mrc_addr_type a, input mrc_addr_type ref_a);
    addr_is = (a == ref_a);
  endfunction

  function automatic logic [4:0] thr_value(input logic [1:0] enc);
    case (enc)
      `MRC_THR_ENC_1: thr_value = `MRC_THR_VAL_1;
      `MRC_THR_ENC_4: thr_value = `MRC_THR_VAL_4;
      `MRC_THR_ENC_8: thr_value = `MRC_THR_VAL_8;
      default: thr_value = `MRC_THR_VAL_16;
    endcase
  endfunction

  localparam logic [`MRC_CS_CNT_W-1:0] CS_MIN = `MRC_CS_CNT_W'(`MRC_CS_MIN_CYC);

  logic cs_n_s;

  mrc_sync #(
    .RESET_VAL(1'b1)
  ) u_cs_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(spi_cs_n),
    .sync_out(cs_n_s)
  );

  logic wr_reset;
  logic wr_cfg;
  logic rd_reset;
  logic rd_cfg;

  assign wr_reset = reg_wr_en && addr_is(reg_addr, `MRC_ADDR_RESET);
  assign wr_cfg = reg_wr_en && addr_is(reg_addr, `MRC_ADDR_DEVICE_CONFIG_PRIMARY);
  assign rd_reset = reg_rd_en && addr_is(reg_addr, `MRC_ADDR_RESET);
  assign rd_cfg = reg_rd_en && addr_is(reg_addr, `MRC_ADDR_DEVICE_CONFIG_PRIMARY);

  // soft reset sequencing
  mrc_rst_state_type rst_state_q;
  mrc_rst_state_type rst_state_d;
  logic [`MRC_CS_CNT_W-1:0] cs_cnt_q;
  logic [`MRC_CS_CNT_W-1:0] cs_cnt_d;
  logic soft_rst_d;

  always_comb begin
    rst_state_d = rst_state_q;
    soft_rst_d = 1'b0;
    cs_cnt_d = cs_cnt_q;
    // chip select low time, saturating
    if (cs_n_s) begin
      cs_cnt_d = '0;
    end else if (cs_cnt_q != CS_MIN) begin
      cs_cnt_d = cs_cnt_q + `MRC_CS_CNT_W'(1);
    end
    case (rst_state_q)
      MRC_RST_IDLE: begin
        if (wr_reset && reg_wr_data[`MRC_RST_TRIGGER_BIT]) begin
          rst_state_d = MRC_RST_ARMED;
        end
      end
      MRC_RST_ARMED: begin
        if (cs_n_s) begin
          if (cs_cnt_q == CS_MIN) begin
            rst_state_d = MRC_RST_FIRE;
            soft_rst_d = 1'b1;
          end else begin
            rst_state_d = MRC_RST_IDLE;
          end
        end
      end
      MRC_RST_FIRE: begin
        rst_state_d = MRC_RST_IDLE;
      end
      default: begin
        rst_state_d = MRC_RST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_state_q <= MRC_RST_IDLE;
      cs_cnt_q <= '0;
      device_soft_reset_q <= 1'b0;
    end else begin
      rst_state_q <= rst_state_d;
      cs_cnt_q <= cs_cnt_d;
      device_soft_reset_q <= soft_rst_d;
    end
  end

  // configuration register
  logic sync_q;
  logic sync_d;
  logic txfcs_q;
  logic txfcs_d;
  logic csalign_q;
  logic csalign_d;
  logic zalign_q;
  logic zalign_d;
  logic [1:0] thr_q;
  logic [1:0] thr_d;
  logic rstc_d;

  always_comb begin
    sync_d = sync_q;
    txfcs_d = txfcs_q;
    csalign_d = csalign_q;
    zalign_d = zalign_q;
    thr_d = thr_q;
    rstc_d = reset_complete_flag_q;
    if (reset_complete_clear) begin
      rstc_d = 1'b0;
    end
    // defaults land together with the pulse
    if (soft_rst_d) begin
      sync_d = 1'b0;
      txfcs_d = 1'b0;
      csalign_d = 1'b0;
      zalign_d = 1'b0;
      thr_d = `MRC_CFG_THR_RESET;
      rstc_d = 1'b1;
    end else if (wr_cfg) begin
      sync_d = sync_q | reg_wr_data[`MRC_CFG_SYNC_BIT];
      txfcs_d = reg_wr_data[`MRC_CFG_TXFCS_BIT];
      csalign_d = reg_wr_data[`MRC_CFG_CSALIGN_BIT];
      zalign_d = reg_wr_data[`MRC_CFG_ZALIGN_BIT];
      thr_d = reg_wr_data[`MRC_CFG_THR_MSB:`MRC_CFG_THR_LSB];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_q <= 1'b0;
      txfcs_q <= 1'b0;
      csalign_q <= 1'b0;
      zalign_q <= 1'b0;
      thr_q <= `MRC_CFG_THR_RESET;
      reset_complete_flag_q <= 1'b1;
    end else begin
      sync_q <= sync_d;
      txfcs_q <= txfcs_d;
      csalign_q <= csalign_d;
      zalign_q <= zalign_d;
      thr_q <= thr_d;
      reset_complete_flag_q <= rstc_d;
    end
  end

  // register reads
  mrc_word_type rd_data_d;

  always_comb begin
    rd_data_d = '0;
    if (rd_cfg) begin
      rd_data_d[`MRC_CFG_SYNC_BIT] = sync_q;
      rd_data_d[`MRC_CFG_TXFCS_BIT] = txfcs_q;
      rd_data_d[`MRC_CFG_CSALIGN_BIT] = csalign_q;
      rd_data_d[`MRC_CFG_ZALIGN_BIT] = zalign_q;
      rd_data_d[`MRC_CFG_THR_MSB:`MRC_CFG_THR_LSB] = thr_q;
      rd_data_d[`MRC_CFG_LOW_MSB:`MRC_CFG_LOW_LSB] = `MRC_CFG_LOW_VALUE;
    end else if (rd_reset) begin
      rd_data_d = '0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rd_data_q <= '0;
      reg_rd_valid_q <= 1'b0;
    end else begin
      reg_rd_data_q <= rd_data_d;
      reg_rd_valid_q <= reg_rd_en;
    end
  end

  // effective settings and framing
  logic csa_eff;
  logic za_eff;
  logic [4:0] thr_eff;
  logic start_ok_d;
  logic credit_d;
  logic irq_n_d;

  always_comb begin
    csa_eff = csalign_q && oa_protocol_sel;
    za_eff = zalign_q && oa_protocol_sel;
    thr_eff = oa_protocol_sel ? thr_value(thr_q) : `MRC_THR_VAL_1;
    start_ok_d = 1'b1;
    if (csa_eff && !(rx_chunk_first && rx_word_at_chunk_start)) begin
      start_ok_d = 1'b0;
    end
    if (za_eff && !rx_word_at_chunk_start) begin
      start_ok_d = 1'b0;
    end
    credit_d = (free_tx_credits >= CREDIT_W'(thr_eff));
    irq_n_d = !(rstc_d || credit_d);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      footer_sync_q <= 1'b0;
      tx_check_seq_validate_en_q <= 1'b0;
      select_aligned_rx_frame_en_q <= 1'b0;
      zero_aligned_rx_frame_en_q <= 1'b0;
      rx_frame_start_ok_q <= 1'b1;
      tx_credit_irq_q <= 1'b0;
      host_interrupt_n_q <= 1'b0;
    end else begin
      footer_sync_q <= sync_d;
      tx_check_seq_validate_en_q <= txfcs_d;
      select_aligned_rx_frame_en_q <= csa_eff;
      zero_aligned_rx_frame_en_q <= za_eff;
      rx_frame_start_ok_q <= start_ok_d;
      tx_credit_irq_q <= credit_d;
      host_interrupt_n_q <= irq_n_d;
    end
  end

endmodule // mrc_regs

`default_nettype wire

// [tb/mrc_regs_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module mrc_regs_chk #(
  parameter int CREDIT_W = 6
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic spi_cs_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire mrc_pkg::mrc_addr_type reg_addr,
  input wire mrc_pkg::mrc_word_type reg_wr_data,
  input wire logic [CREDIT_W-1:0] free_tx_credits,
  input wire mrc_pkg::mrc_word_type reg_rd_data_q,
  input wire logic reg_rd_valid_q,
  input wire logic device_soft_reset_q,
  input wire logic footer_sync_q,
  input wire logic reset_complete_flag_q,
  input wire logic tx_credit_irq_q,
  input wire logic host_interrupt_n_q
);
  import mrc_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  property p_rst_zero;
    reg_rd_en && reg_addr == 8'h03 |=> reg_rd_valid_q && reg_rd_data_q == 32'h0;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("reset reg read");
  property p_sync_set;
    reg_wr_en && reg_addr == 8'h04 && reg_wr_data[15] |=> footer_sync_q;
  endproperty
  a_sync_set: assert property (p_sync_set) else $error("sync set");
  property p_sync_hold;
    footer_sync_q ##1 !device_soft_reset_q |-> footer_sync_q;
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync hold");
  property p_srst_clr;
    device_soft_reset_q |-> !footer_sync_q && reset_complete_flag_q && !host_interrupt_n_q;
  endproperty
  a_srst_clr: assert property (p_srst_clr) else $error("soft reset state");
  property p_srst_pulse;
    device_soft_reset_q |-> spi_cs_n ##1 !device_soft_reset_q;
  endproperty
  a_srst_pulse: assert property (p_srst_pulse) else $error("soft reset pulse");
  property p_irq;
    reset_complete_flag_q || tx_credit_irq_q |-> !host_interrupt_n_q;
  endproperty
  a_irq: assert property (p_irq) else $error("irq level");
  property p_no_cred;
    free_tx_credits == '0 |=> !tx_credit_irq_q;
  endproperty
  a_no_cred: assert property (p_no_cred) else $error("credit irq low");
  property p_full_cred;
    free_tx_credits >= 16 |=> tx_credit_irq_q;
  endproperty
  a_full_cred: assert property (p_full_cred) else $error("credit irq high");
endmodule // mrc_regs_chk
bind mrc_regs mrc_regs_chk #(.CREDIT_W(CREDIT_W)) u_chk (.clk(clk), .reset_n(reset_n),
  .spi_cs_n(spi_cs_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
  .reg_wr_data(reg_wr_data), .free_tx_credits(free_tx_credits),
  .reg_rd_data_q(reg_rd_data_q), .reg_rd_valid_q(reg_rd_valid_q),
  .device_soft_reset_q(device_soft_reset_q), .footer_sync_q(footer_sync_q),
  .reset_complete_flag_q(reset_complete_flag_q), .tx_credit_irq_q(tx_credit_irq_q),
  .host_interrupt_n_q(host_interrupt_n_q));
`default_nettype wire

// [tb/mrc_host.sv]
`timescale 1ns/100ps
`default_nettype none
module mrc_host (
  input wire logic clk,
  output logic cs_n,
  output logic wr,
  output logic rd,
  output mrc_pkg::mrc_addr_type addr,
  output mrc_pkg::mrc_word_type wd
);
  import mrc_pkg::*;
  initial begin
    cs_n = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wd = 32'h0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one strobe cycle, then lines flipped
  task automatic acc(input logic w, input mrc_addr_type a, input mrc_word_type d);
    cyc(1);
    addr = a;
    wd = d;
    wr = w;
    rd = !w;
    cyc(1);
    wr = 1'b0;
    rd = 1'b0;
    addr = ~a;
    wd = ~d;
  endtask
  task automatic sel(input logic v, input int n);
    cyc(1);
    cs_n = v;
    cyc(n);
  endtask
endmodule // mrc_host
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import mrc_pkg::*;
  typedef struct {mrc_addr_type a; mrc_word_type d; mrc_word_type e;} mrc_row_type;
  mrc_row_type rows [6] = '{'{8'h04, 32'h00004000, 32'h00004006},
    '{8'h04, 32'h00003C00, 32'h00003C06}, '{8'h04, 32'hFFFF83FF, 32'h00008006},
    '{8'h04, 32'h00000000, 32'h00008006}, '{8'h03, 32'hFFFFFFFE, 32'h00000000},
    '{8'h7F, 32'hFFFFFFFF, 32'h00000000}};
  logic [5:0] thr [4] = '{6'h01, 6'h04, 6'h08, 6'h10};
  logic clk = 1'b0;
  logic reset_n;
  logic oa;
  logic clr;
  logic first;
  logic w0;
  logic [5:0] cred;
  wire logic cs_n, wr, rd;
  wire mrc_addr_type addr;
  wire mrc_word_type wd;
  mrc_word_type rdd;
  logic rdv, srst, sync, fcs, csa, za, sok, rc, tirq, irq_n;
  int fail_count = 0;
  int check_count = 0;
  int n;
  always #5 clk = ~clk;
  mrc_host host (.clk(clk), .cs_n(cs_n), .wr(wr), .rd(rd), .addr(addr), .wd(wd));
  mrc_regs dut (.clk(clk), .reset_n(reset_n), .spi_cs_n(cs_n), .oa_protocol_sel(oa),
    .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr), .reg_wr_data(wd),
    .reset_complete_clear(clr), .free_tx_credits(cred), .rx_chunk_first(first),
    .rx_word_at_chunk_start(w0), .reg_rd_data_q(rdd), .reg_rd_valid_q(rdv),
    .device_soft_reset_q(srst), .footer_sync_q(sync), .tx_check_seq_validate_en_q(fcs),
    .select_aligned_rx_frame_en_q(csa), .zero_aligned_rx_frame_en_q(za),
    .rx_frame_start_ok_q(sok), .reset_complete_flag_q(rc), .tx_credit_irq_q(tirq),
    .host_interrupt_n_q(irq_n));
  task automatic chk(input string s, input mrc_word_type e, input mrc_word_type g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    close_out();
  end
  initial begin
    reset_n = 1'b0;
    oa = 1'b1;
    clr = 1'b0;
    first = 1'b0;
    w0 = 1'b0;
    cred = 6'h00;
    repeat (8) @(posedge clk);
    #1 reset_n = 1'b1;
    chk("rc", 1, rc);
    chk("irq", 0, irq_n);
    host.acc(1'b0, 8'h04, 32'h0);
    chk("rd", 32'h6, rdd);
    foreach (rows[i]) begin
      host.acc(1'b1, rows[i].a, rows[i].d);
      host.acc(1'b0, rows[i].a, 32'h0);
      chk("rdv", 1, rdv);
      chk("rd", rows[i].e, rdd);
    end
    chk("sync", 1, sync);
    host.acc(1'b1, 8'h04, 32'h00003000);
    w0 = 1'b1;
    host.cyc(2);
    chk("csa", 1, csa);
    chk("sok", 0, sok);
    first = 1'b1;
    host.cyc(2);
    chk("sok", 1, sok);
    w0 = 1'b0;
    host.cyc(2);
    chk("sok", 0, sok);
    oa = 1'b0;
    host.cyc(2);
    chk("za", 0, za);
    chk("csa", 0, csa);
    chk("sok", 1, sok);
    oa = 1'b1;
    host.acc(1'b1, 8'h04, 32'h00001000);
    first = 1'b0;
    w0 = 1'b1;
    host.cyc(2);
    chk("za", 1, za);
    chk("sok", 1, sok);
    w0 = 1'b0;
    host.cyc(2);
    chk("sok", 0, sok);
    clr = 1'b1;
    host.cyc(1);
    clr = 1'b0;
    for (int i = 0; i < 4; i++) begin
      host.acc(1'b1, 8'h04, {20'h0, i[1:0], 10'h0});
      cred = thr[i] - 6'h01;
      host.cyc(2);
      chk("tirq", 0, tirq);
      chk("irq", 1, irq_n);
      cred = thr[i];
      host.cyc(2);
      chk("irq", 0, irq_n);
    end
    cred = 6'h01;
    oa = 1'b0;
    host.cyc(2);
    chk("tirq", 1, tirq);
    host.acc(1'b1, 8'h04, 32'h00004000);
    chk("fcs", 1, fcs);
    host.sel(1'b0, 1);
    host.acc(1'b1, 8'h03, 32'h00000001);
    host.sel(1'b1, 8);
    chk("sync", 1, sync);
    host.sel(1'b0, 12);
    host.acc(1'b1, 8'h03, 32'h00000001);
    host.cyc(4);
    chk("sync", 1, sync);
    clr = 1'b1;
    host.sel(1'b1, 0);
    for (n = 0; n < 8 && srst !== 1'b1; n++) host.cyc(1);
    chk("srst", 1, srst);
    chk("srst_lat", 3, n);
    chk("rc", 1, rc);
    chk("irq", 0, irq_n);
    chk("sync", 0, sync);
    chk("fcs", 0, fcs);
    clr = 1'b0;
    host.acc(1'b0, 8'h03, 32'h0);
    chk("srst", 0, srst);
    chk("rd", 0, rdd);
    host.acc(1'b0, 8'h04, 32'h0);
    chk("rd", 32'h6, rdd);
    host.acc(1'b1, 8'h04, 32'h00008000);
    cred = 6'h00;
    clr = 1'b1;
    host.cyc(2);
    clr = 1'b0;
    chk("sync", 1, sync);
    chk("rc", 0, rc);
    chk("irq", 1, irq_n);
    reset_n = 1'b0;
    host.cyc(2);
    reset_n = 1'b1;
    chk("sync", 0, sync);
    chk("rc", 1, rc);
    chk("irq", 0, irq_n);
    chk("rdv", 0, rdv);
    host.acc(1'b0, 8'h04, 32'h0);
    chk("rd", 32'h6, rdd);
    close_out();
  end
endmodule // tb_top
`default_nettype wire
